// file: hdl/mcs_defines.svh
/*
 * Offsets, field positions, reset values and unmapped read data of the
 * modem control and status block.
 * Assumes inclusion by bare name from files under hdl/.
 */
// Behaviour
// R1 - Serial output stays at mark when disabled, reset, idle or looping.
// R2 - Clear-to-send input never affects the serial output.
// R3 - Status bit 4 shows the inverted clear-to-send pin.
// R4 - Clear-to-send change since last status read sets status bit 0.
// R5 - Loop mode works regardless of the clear-to-send pin.
// R6 - Software stops sending while clear-to-send is inactive.
// R7 - Status bit 5 shows the inverted data-set-ready pin.
// R8 - Data-set-ready change since last status read sets status bit 1.
// R9 - Control bit 0 set drives terminal-ready low; clear or reset raises it.
// R10 - Control bit 1 set drives request-to-send low; reset raises it.
// R11 - Rate clock output runs at oscillator divided by 16-bit divisor.
// R12 - Control bit 2 set drives user output one low; reset raises it.
// R13 - Loop mode holds user output one high.
// R14 - Control bit 3 set drives user output two low; reset raises it.
// R15 - Loop mode holds user output two high.
// R16 - Master reset clears control register, outputs and suspends serial.
// R17 - Reading status clears both change flags; the code clears only flags set in the captured read data.
`ifndef MCS_DEFINES_SVH
`define MCS_DEFINES_SVH

`define MCS_ADDR_W 4
`define MCS_OFS_CTRL 4'h0
`define MCS_OFS_STAT 4'h4
`define MCS_OFS_DIVLO 4'h8
`define MCS_OFS_DIVHI 4'hC

`define MCS_CTRL_DTR 0
`define MCS_CTRL_RTS 1
`define MCS_CTRL_USR1 2
`define MCS_CTRL_USR2 3
`define MCS_CTRL_LOOP 4
`define MCS_CTRL_TXEN 5
`define MCS_CTRL_RESET 8'h00

`define MCS_STAT_CTS_CHG 0
`define MCS_STAT_DSR_CHG 1
`define MCS_STAT_CTS 4
`define MCS_STAT_DSR 5

`define MCS_DIV_RESET 16'h0001
`define MCS_UNMAPPED_DATA 32'h00000000

`endif

// file: hdl/mcs_modem_ctrl.sv
/*
 * Modem control and status registers with Avalon-MM slave, modem pins,
 * serial output idle control and the 16x rate clock output.
 * Assumes modem pins are asynchronous and the transmitter sits elsewhere.
 */
// Our own choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`include "mcs_defines.svh"
module mcs_modem_ctrl
    import mcs_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic masterResetIn,
    input wire logic [`MCS_ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic clearSendN,
    input wire logic setReadyN,
    input wire logic txShiftEmpty,
    input wire logic txSerialData,
    output logic serialOutPin,
    output logic termReadyN,
    output logic reqSendN,
    output logic userOutputOneN,
    output logic userOutputTwoN,
    output logic rateClockOut,
    output logic loopModeOut
);
    typedef struct packed {
        mcs_bus_t bus;
        logic [31:0] rdata;
        logic [7:0] ctrl;
        logic [7:0] divLo;
        logic [7:0] divHi;
        logic [1:0] ctsSync;
        logic [1:0] dsrSync;
        logic [1:0] mresSync;
        logic ctsPrev;
        logic dsrPrev;
        logic ctsChgFlag;
        logic dsrChgFlag;
        logic serOut;
        logic dtrN;
        logic rtsN;
        logic usr1N;
        logic usr2N;
        logic rclk;
        logic waitReq;
    } mcs_state_t;

    mcs_state_t st_ff;
    mcs_state_t nxt_st;
    mcs_rate_if rateBus ();

    logic ctsNow;
    logic dsrNow;
    logic mresNow;
    logic statRead;

    assign ctsNow = st_ff.ctsSync[1];
    assign dsrNow = st_ff.dsrSync[1];
    assign mresNow = st_ff.mresSync[1];
    assign statRead = (st_ff.bus == MCS_ACK) && read
        && (address == `MCS_OFS_STAT);

    // One divider tick is one rate clock cycle, so the output is a pulse
    // one clk wide; a divisor of one therefore holds it high.
    assign rateBus.divisor = {st_ff.divHi, st_ff.divLo};
    assign rateBus.enable = !mresNow;

    mcs_rate_div uDiv (
        .clk(clk),
        .srst(srst),
        .rate(rateBus)
    );

    function automatic logic [31:0] mcs_read_mux(
        input logic [`MCS_ADDR_W-1:0] a,
        input mcs_state_t s
    );
        logic [31:0] d;
        d = `MCS_UNMAPPED_DATA;
        case (a)
            `MCS_OFS_CTRL: d = {24'h000000, s.ctrl};
            `MCS_OFS_STAT: begin
                d[`MCS_STAT_CTS_CHG] = s.ctsChgFlag;
                d[`MCS_STAT_DSR_CHG] = s.dsrChgFlag;
                d[`MCS_STAT_CTS] = !s.ctsSync[1]; // R3
                d[`MCS_STAT_DSR] = !s.dsrSync[1]; // R7
            end
            `MCS_OFS_DIVLO: d = {24'h000000, s.divLo};
            `MCS_OFS_DIVHI: d = {24'h000000, s.divHi};
            default: d = `MCS_UNMAPPED_DATA;
        endcase
        return d;
    endfunction

    always_comb begin
        nxt_st = st_ff;
        nxt_st.ctsSync = {st_ff.ctsSync[0], clearSendN};
        nxt_st.dsrSync = {st_ff.dsrSync[0], setReadyN};
        nxt_st.mresSync = {st_ff.mresSync[0], masterResetIn};
        nxt_st.ctsPrev = ctsNow;
        nxt_st.dsrPrev = dsrNow;

        // Bus handshake: request seen in IDLE, answered in ACK, then HOLD.
        case (st_ff.bus)
            MCS_IDLE: begin
                if (read || write) begin
                    nxt_st.bus = MCS_ACK;
                    nxt_st.rdata = mcs_read_mux(address, st_ff);
                end
            end
            MCS_ACK: begin
                nxt_st.bus = MCS_HOLD;
                if (write) begin
                    case (address)
                        `MCS_OFS_CTRL: nxt_st.ctrl = writedata[7:0];
                        `MCS_OFS_DIVLO: nxt_st.divLo = writedata[7:0];
                        `MCS_OFS_DIVHI: nxt_st.divHi = writedata[7:0];
                        default: nxt_st.ctrl = st_ff.ctrl;
                    endcase
                end
            end
            MCS_HOLD: nxt_st.bus = MCS_IDLE;
            default: nxt_st.bus = MCS_IDLE;
        endcase
        // Waitrequest is registered and low only in the ACK cycle.
        nxt_st.waitReq = (nxt_st.bus != MCS_ACK);

        // A read clears only the flags it reported; a change that arrives
        // after the capture, or in the clearing cycle itself, still sets.
        if (statRead) begin
            nxt_st.ctsChgFlag = st_ff.ctsChgFlag
                && !st_ff.rdata[`MCS_STAT_CTS_CHG]; // R17
            nxt_st.dsrChgFlag = st_ff.dsrChgFlag
                && !st_ff.rdata[`MCS_STAT_DSR_CHG]; // R17
        end
        if (ctsNow != st_ff.ctsPrev) begin
            nxt_st.ctsChgFlag = 1'b1; // R4
        end
        if (dsrNow != st_ff.dsrPrev) begin
            nxt_st.dsrChgFlag = 1'b1; // R8
        end

        if (mresNow) begin
            nxt_st.ctrl = `MCS_CTRL_RESET; // R16
        end

        // Clear-to-send is deliberately absent from every term below.
        nxt_st.dtrN = !nxt_st.ctrl[`MCS_CTRL_DTR]; // R9
        nxt_st.rtsN = !nxt_st.ctrl[`MCS_CTRL_RTS]; // R10
        nxt_st.usr1N = !(nxt_st.ctrl[`MCS_CTRL_USR1]
            && !nxt_st.ctrl[`MCS_CTRL_LOOP]); // R12 R13
        nxt_st.usr2N = !(nxt_st.ctrl[`MCS_CTRL_USR2]
            && !nxt_st.ctrl[`MCS_CTRL_LOOP]); // R14 R15
        if (mresNow || !nxt_st.ctrl[`MCS_CTRL_TXEN] || txShiftEmpty
            || nxt_st.ctrl[`MCS_CTRL_LOOP]) begin
            nxt_st.serOut = 1'b1; // R1 R2 R5
        end else begin
            nxt_st.serOut = txSerialData; // R2
        end

        if (mresNow) begin
            nxt_st.rclk = 1'b0; // R16
        end else begin
            nxt_st.rclk = rateBus.tick; // R11
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_ff.bus <= MCS_IDLE;
            st_ff.rdata <= 32'h00000000;
            st_ff.ctrl <= `MCS_CTRL_RESET;
            st_ff.divLo <= 8'(`MCS_DIV_RESET);
            st_ff.divHi <= 8'(`MCS_DIV_RESET >> 8);
            st_ff.ctsSync <= 2'h3;
            st_ff.dsrSync <= 2'h3;
            st_ff.mresSync <= 2'h0;
            st_ff.ctsPrev <= 1'b1;
            st_ff.dsrPrev <= 1'b1;
            st_ff.ctsChgFlag <= 1'b0;
            st_ff.dsrChgFlag <= 1'b0;
            st_ff.serOut <= 1'b1;
            st_ff.dtrN <= 1'b1;
            st_ff.rtsN <= 1'b1;
            st_ff.usr1N <= 1'b1;
            st_ff.usr2N <= 1'b1;
            st_ff.rclk <= 1'b0;
            st_ff.waitReq <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign readdata = st_ff.rdata;
    assign waitrequest = st_ff.waitReq;
    assign serialOutPin = st_ff.serOut;
    assign termReadyN = st_ff.dtrN;
    assign reqSendN = st_ff.rtsN;
    assign userOutputOneN = st_ff.usr1N;
    assign userOutputTwoN = st_ff.usr2N;
    assign rateClockOut = st_ff.rclk;
    assign loopModeOut = st_ff.ctrl[`MCS_CTRL_LOOP];
endmodule

// file: hdl/mcs_pkg.sv
/*
 * Types shared by the modem control and status block.
 * Assumes the defines header is available for inclusion.
 */
package mcs_pkg;
    typedef enum logic [2:0] {
        MCS_IDLE = 3'b001,
        MCS_ACK = 3'b010,
        MCS_HOLD = 3'b100
    } mcs_bus_t;
endpackage

// file: hdl/mcs_rate_div.sv
/*
 * Divider producing a one-cycle tick every divisor cycles.
 * Assumes a divisor of zero is treated as one.
 */
`timescale 1ns/1ps
module mcs_rate_div
    import mcs_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    mcs_rate_if.gen rate
);
    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } mcs_div_t;

    mcs_div_t st_ff;
    mcs_div_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (!rate.enable) begin
            nxt_st.cnt = 16'h0000;
        end else if (st_ff.cnt + 16'h0001 >= rate.divisor) begin
            nxt_st.cnt = 16'h0000;
            nxt_st.tick = 1'b1; // R11
        end else begin
            nxt_st.cnt = st_ff.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rate.tick = st_ff.tick;
endmodule

// file: hdl/mcs_rate_if.sv
/*
 * Interface carrying the divisor and rate pulse between top and divider.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface mcs_rate_if;
    logic [15:0] divisor;
    logic enable;
    logic tick;
    modport ctrl (output divisor, output enable, input tick);
    modport gen (input divisor, input enable, output tick);
endinterface

// file: test/mcs_checker.sv
/* Port checker for the modem control block.
   Assumes it is bound to every mcs_modem_ctrl instance. */
`timescale 1ns/1ps
`include "mcs_defines.svh"
module mcs_checker
    import mcs_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic masterResetIn,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic clearSendN,
    input wire logic txShiftEmpty,
    input wire logic serialOutPin,
    input wire logic termReadyN,
    input wire logic reqSendN,
    input wire logic userOutputOneN,
    input wire logic userOutputTwoN,
    input wire logic loopModeOut
);
    logic cw, sr;
    logic [4:0] wd_ff;
    assign cw = write && !waitrequest && address == `MCS_OFS_CTRL;
    assign sr = read && !waitrequest && address == `MCS_OFS_STAT;
    always_ff @(posedge clk) if (cw) wd_ff <= writedata[4:0];
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    property p_ser_out;
        $past(txShiftEmpty) || loopModeOut && $past(loopModeOut)
            |-> serialOutPin;
    endproperty
    a_ser_out: assert property (p_ser_out)
        else $error("serial out left mark");
    property p_loop;
        loopModeOut && $past(loopModeOut)
            |-> userOutputOneN && userOutputTwoN;
    endproperty
    a_loop: assert property (p_loop)
        else $error("user output active in loop");
    property p_dtr;
        cw && !$past(masterResetIn, 2) |=> ##[0:1]
            termReadyN == !wd_ff[0];
    endproperty
    a_dtr: assert property (p_dtr)
        else $error("terminal ready wrong");
    property p_rts;
        cw && !$past(masterResetIn, 2) |=> ##[0:1]
            reqSendN == !wd_ff[1];
    endproperty
    a_rts: assert property (p_rts)
        else $error("request to send wrong");
    property p_out;
        cw && !$past(masterResetIn, 2) |=> ##[0:1]
            userOutputOneN == !(wd_ff[2] && !wd_ff[4]) &&
            userOutputTwoN == !(wd_ff[3] && !wd_ff[4]);
    endproperty
    a_out: assert property (p_out)
        else $error("user outputs wrong");
    property p_mres;
        masterResetIn[*5] |-> termReadyN && reqSendN &&
            userOutputOneN && userOutputTwoN;
    endproperty
    a_mres: assert property (p_mres)
        else $error("outputs active under master reset");
    property p_ans;
        $rose(read || write) |-> ##[1:3] !waitrequest;
    endproperty
    a_ans: assert property (p_ans)
        else $error("bus access not answered");
    property p_cts;
        $stable(clearSendN)[*5] ##0 sr |-> readdata[4] == !clearSendN;
    endproperty
    a_cts: assert property (p_cts)
        else $error("status clear to send bit wrong");
    property p_cts_chg;
        $changed(clearSendN) ##1 (!sr)[*5] ##1 sr |-> readdata[0];
    endproperty
    a_cts_chg: assert property (p_cts_chg)
        else $error("clear to send change not flagged");
    c_wr: cover property (cw);
    c_rd: cover property (sr);
    c_mres: cover property (masterResetIn[*5]);
endmodule
bind mcs_modem_ctrl mcs_checker i_mcs_checker(.*);

// file: test/mcs_modem_ctrl_tb_top.sv
/* Self-checking bench for the modem control block.
   Assumes the checker is bound and the modem model drives the pins. */
`timescale 1ns/1ps
`include "mcs_defines.svh"
module mcs_modem_ctrl_tb_top
    import mcs_pkg::*;
;
    logic clk = 1'h0, srst = 1'h1, masterResetIn = 1'h0;
    logic txShiftEmpty = 1'h1, txSerialData = 1'h1;
    logic read = 1'h0, write = 1'h0;
    logic [3:0] address = 4'h0;
    logic [1:0] act = 2'h0;
    logic [31:0] writedata = 32'h0, readdata, rd;
    logic waitrequest, clearSendN, setReadyN, serialOutPin, termReadyN;
    logic reqSendN, userOutputOneN, userOutputTwoN, rateClockOut;
    logic loopModeOut;
    int fail_count = 0, tests_run = 0;
    time t0;
    always #20 clk = ~clk;
    mcs_modem_ctrl i_mcs_modem_ctrl(.*);
    mcs_modem_model i_mcs_modem_model(.*);
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    task results;
        $display("fail_count %0d tests_run %0d", fail_count, tests_run);
        if (fail_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        read <= !w;
        write <= w;
        @(posedge clk);
        while (waitrequest !== 1'h0) @(posedge clk);
        rd = readdata;
        read <= 1'h0;
        write <= 1'h0;
        @(posedge clk);
    endtask
    task rc(input logic [3:0] a, input logic [31:0] e);
        acc(1'h0, a, 32'h0);
        chk("readdata", e, rd);
    endtask
    task pins(input logic [3:0] e);
        repeat (6) @(posedge clk);
        chk("modem outs", e,
            {termReadyN, reqSendN, userOutputOneN, userOutputTwoN});
    endtask
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'h0;
        @(posedge clk);
        rc(`MCS_OFS_CTRL, 32'h0);
        rc(`MCS_OFS_DIVLO, 32'h1);
        rc(4'h2, 32'h0);
        rc(`MCS_OFS_STAT, 32'h0);
        pins(4'hF);
        acc(1'h1, `MCS_OFS_CTRL, 32'h0F);
        pins(4'h0);
        chk("loop out", 32'h0, loopModeOut);
        acc(1'h1, `MCS_OFS_CTRL, 32'h1E);
        pins(4'hB);
        chk("loop out", 32'h1, loopModeOut);
        chk("serial_out_pin", 32'h1, serialOutPin);
        act <= 2'h1;
        pins(4'hB);
        chk("serial_out_pin", 32'h1, serialOutPin);
        rc(`MCS_OFS_STAT, 32'h11);
        rc(`MCS_OFS_STAT, 32'h10);
        act <= 2'h3;
        repeat (6) @(posedge clk);
        rc(`MCS_OFS_STAT, 32'h32);
        rc(`MCS_OFS_STAT, 32'h30);
        acc(1'h1, `MCS_OFS_CTRL, 32'h20);
        txShiftEmpty <= 1'h0;
        txSerialData <= 1'h0;
        repeat (3) @(posedge clk);
        chk("serial_out_pin", 32'h0, serialOutPin);
        act <= 2'h2;
        repeat (6) @(posedge clk);
        chk("serial_out_pin", 32'h0, serialOutPin);
        txShiftEmpty <= 1'h1;
        repeat (3) @(posedge clk);
        chk("serial_out_pin", 32'h1, serialOutPin);
        acc(1'h1, `MCS_OFS_CTRL, 32'h0F);
        masterResetIn <= 1'h1;
        pins(4'hF);
        rc(`MCS_OFS_CTRL, 32'h0);
        masterResetIn <= 1'h0;
        acc(1'h1, `MCS_OFS_DIVLO, 32'h3);
        acc(1'h1, `MCS_OFS_DIVHI, 32'h0);
        repeat (2) @(posedge rateClockOut);
        t0 = $time;
        @(posedge rateClockOut);
        chk("rate period", 32'h3, 32'(($time - t0) / 40));
        results();
    end
    initial begin
        #200000;
        fail_count++;
        results();
    end
endmodule

// file: test/mcs_modem_model.sv
/* Modem model driving the active-low status pins.
   Assumes act bit 0 asks clear-to-send, bit 1 data-set-ready. */
`timescale 1ns/1ps
module mcs_modem_model(
    input wire logic clk,
    input wire logic [1:0] act,
    output logic clearSendN,
    output logic setReadyN
);
    initial {setReadyN, clearSendN} = 2'h3;
    always @(posedge clk) {setReadyN, clearSendN} <= ~act;
endmodule
